// ==== icl_core_model.sv ====
// Purpose: Core model that takes requested interrupts
// Assumes: LAT of at least 2, so a request can drop before the next take
// Notes:   A high request is taken before a low one
`timescale 1ns/1ps
module icl_core_model #(
  parameter int LAT = 3
) (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  // Requests and acknowledges
  input  wire icl_pkg::icl_core_req_t req,
  output logic                        ack_high,
  output logic                        ack_low
);
  import icl_pkg::*;
  // ==========================================================
  // Take a request once it has stood for LAT+1 cycles
  int cnt_ff;
  always_ff @(posedge sys_clk) begin
    ack_high <= 1'b0;
    ack_low  <= 1'b0;
    if (rst) begin
      cnt_ff <= 0;
    end else if (req == 2'b00) begin
      cnt_ff <= 0;
    end else if (cnt_ff == LAT) begin
      cnt_ff   <= 0;
      ack_high <= req.req_high;
      ack_low  <= !req.req_high;
    end else begin
      cnt_ff <= cnt_ff + 1;
    end
  end
endmodule : icl_core_model

// ==== icl_edge_det.sv ====
// Purpose: Edge detector for one external interrupt pin
// Assumes: Pin is synchronous to sys_clk
// Notes:   No event in the first cycle after reset
`timescale 1ns/1ps
module icl_edge_det (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Pin and polarity
  input  wire logic pin,
  input  wire logic rise_sel,
  // Event pulse
  output logic      evt
);
  logic prev_ff;
  logic armed_ff;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prev_ff  <= 1'b0;
      armed_ff <= 1'b0;
    end else begin
      prev_ff  <= pin;
      armed_ff <= 1'b1;
    end
  end

  assign evt = armed_ff & (rise_sel ? (pin & ~prev_ff) : (~pin & prev_ff));

  // ==========================================================
  // Checks
  AST_EDGE_POL: assert property ( // see RULE6
    @(posedge sys_clk) disable iff (rst)
    evt |-> (rise_sel ? $rose(pin) : $fell(pin)))
    else $error("pin event on wrong edge");
endmodule : icl_edge_det

// ==== icl_flag_cell.sv ====
// Purpose: Group of sticky flags, set by hardware, cleared by software
// Assumes: set and clr are one-cycle pulses per bit
// Notes:   A set in the clearing cycle wins
`timescale 1ns/1ps
module icl_flag_cell #(
  parameter int W = 3
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // Set and clear
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  // Flags
  output logic      [W-1:0] q_ff
);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q_ff <= '0;
    end else begin
      q_ff <= (q_ff & ~clr) | set;
    end
  end

  // ==========================================================
  // Checks
  AST_FLAG_SET: assert property ( // see RULE7
    @(posedge sys_clk) disable iff (rst)
    set != '0 |=> (q_ff & $past(set)) == $past(set))
    else $error("flag not set by its event");
  AST_GATE_HOLD: assert property ( // see RULE10
    @(posedge sys_clk) disable iff (rst)
    (q_ff & ~clr) != '0 |=>
      (q_ff & $past(q_ff & ~clr)) == $past(q_ff & ~clr))
    else $error("flag lost without software clear");
endmodule : icl_flag_cell

// ==== icl_pkg.sv ====
// Purpose: Shared constants and carrier types of the interrupt control logic
// Assumes: 8-bit registers, one per aligned 32-bit word on AXI4-Lite
// Notes:   Unimplemented control and analog bits are cleared through the masks below
package icl_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] ADDR_GLOBAL_CTRL = 8'h00;
  localparam logic [7:0] ADDR_GATE_FLAG   = 8'h04;
  localparam logic [7:0] ADDR_ANALOG_EN   = 8'h08;
  localparam logic [7:0] ADDR_EXT_FLAG    = 8'h0c;
  localparam logic [7:0] ADDR_ANALOG_FLAG = 8'h10;
  localparam logic [7:0] ADDR_GATE_EN     = 8'h14;
  localparam logic [7:0] ADDR_EXT_EN      = 8'h18;
  localparam logic [7:0] ADDR_GATE_PRIO   = 8'h1c;
  localparam logic [7:0] ADDR_ANALOG_PRIO = 8'h20;
  localparam logic [7:0] ADDR_EXT_PRIO    = 8'h24;
  // ==========================================================
  // Field positions
  localparam int BIT_GLOBAL_HIGH = 7;
  localparam int BIT_PERIPH_LOW  = 6;
  localparam int BIT_PRIO_ON     = 5;
  localparam int BIT_VDET        = 7;
  localparam int BIT_ZCD         = 6;
  localparam int BIT_CMPB        = 1;
  localparam int BIT_CMPA        = 0;
  // ==========================================================
  // Implemented-bit masks, reset values and response codes
  localparam logic [7:0] MASK_CTRL     = 8'he7;
  localparam logic [7:0] MASK_LOW3     = 8'h07;
  localparam logic [7:0] MASK_ANALOG   = 8'hc3;
  localparam logic [7:0] MASK_EXT_PRIO = 8'h06;
  localparam logic [7:0] RST_CTRL      = 8'h07;
  localparam logic [2:0] RST_ZERO3     = 3'h0;
  localparam logic [3:0] RST_ZERO4     = 4'h0;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;
  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [2:0] gate_evt;   // Timer 5, 3, 1 gate events
    logic [3:0] analog_evt; // Voltage detect, zero cross, cmp b, cmp a
  } icl_src_t;
  typedef struct packed {
    logic ext_irq_pin_c;
    logic ext_irq_pin_b;
    logic ext_irq_pin_a;
  } icl_ext_t;
  typedef struct packed {
    logic req_high;
    logic req_low;
  } icl_core_req_t;
  typedef enum logic [1:0] {
    WR_COLLECT = 2'b01,
    WR_RESP    = 2'b10
  } icl_wr_state_t;
endpackage : icl_pkg

// ==== icl_top.sv ====
// Purpose: Interrupt control logic with AXI4-Lite register access
// Assumes: Core pulses ack_high/ack_low when it takes an interrupt
// Notes:   Flags clear by writing one; edge pins are synchronous
//
// Summary of operation
// RULE1: With priority on, global-high enable allows unmasked interrupts and is cleared only when a high interrupt is taken.
// RULE2: With priority off, global enable allows unmasked interrupts and is cleared when any interrupt is taken.
// RULE3: With priority on, the second enable is the low-priority global enable, cleared only when a low interrupt is taken.
// RULE4: With priority off, the second enable gates all peripheral interrupts.
// RULE5: The priority bit selects two-level or single-level operation and changes both global enables.
// RULE6: Each external pin has an edge select bit, one for rising and zero for falling.
// RULE7: Flags are set on their event regardless of any enable.
// RULE8: Software should clear a flag before enabling its interrupt.
// RULE9: Unimplemented bits read as zero.
// RULE10: Timer 5, 3, 1 gate events set bits 2, 1, 0 of the gate flag register and only software clears them.
// RULE11: Analog enable bit 7 enables voltage detect and bit 6 zero cross.
// RULE12: Analog enable bit 1 enables comparator b and bit 0 comparator a.
// RULE13: A request goes to the core when flag, enable and level enable are set; high preempts low.
`timescale 1ns/1ps
module icl_top (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  // AXI4-Lite write
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // Event sources and pins
  input  wire icl_pkg::icl_src_t      src_in,
  input  wire icl_pkg::icl_ext_t      ext_pins,
  // Core side
  input  wire logic                   ack_high,
  input  wire logic                   ack_low,
  output icl_pkg::icl_core_req_t      core_req_ff,
  output logic                        irq_ff
);
  import icl_pkg::*;

  // ==========================================================
  // Declarations
  icl_wr_state_t wr_st_ff;
  icl_wr_state_t nxt_wr_st;
  logic       aw_got_ff;
  logic       w_got_ff;
  logic [7:0] aw_addr_ff;
  logic [7:0] wdata_ff;
  logic       wstrb0_ff;
  logic       awready_ff, wready_ff, arready_ff;
  logic       bvalid_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [7:0] rdata_ff;
  logic       ghe_ff, ple_ff, pri_ff;
  logic [2:0] edge_ff;
  logic [2:0] gate_en_ff;
  logic [2:0] ext_en_ff;
  logic [3:0] an_en_ff;
  logic [2:0] gate_prio_ff;
  logic [3:0] an_prio_ff;
  logic [1:0] ext_prio_ff;
  logic [2:0] ext_flag_w;
  logic [2:0] gate_flag_w;
  logic [3:0] an_flag_w;
  logic [2:0] ext_evt;
  logic [2:0] ext_pin_vec;

  // ==========================================================
  // Handshakes and write channel decode
  wire aw_hs   = s_axi_awvalid & awready_ff;
  wire w_hs    = s_axi_wvalid & wready_ff;
  wire ar_hs   = s_axi_arvalid & arready_ff;
  wire b_hs    = bvalid_ff & s_axi_bready;
  wire r_hs    = rvalid_ff & s_axi_rready;
  wire wr_fire = aw_got_ff & w_got_ff & (wr_st_ff == WR_COLLECT);
  wire wr_en   = wr_fire & wstrb0_ff;
  wire sel_ctrl   = aw_addr_ff == ADDR_GLOBAL_CTRL;
  wire sel_gflag  = aw_addr_ff == ADDR_GATE_FLAG;
  wire sel_an_en  = aw_addr_ff == ADDR_ANALOG_EN;
  wire sel_eflag  = aw_addr_ff == ADDR_EXT_FLAG;
  wire sel_aflag  = aw_addr_ff == ADDR_ANALOG_FLAG;
  wire sel_g_en   = aw_addr_ff == ADDR_GATE_EN;
  wire sel_e_en   = aw_addr_ff == ADDR_EXT_EN;
  wire sel_gprio  = aw_addr_ff == ADDR_GATE_PRIO;
  wire sel_aprio  = aw_addr_ff == ADDR_ANALOG_PRIO;
  wire sel_eprio  = aw_addr_ff == ADDR_EXT_PRIO;
  wire wr_hit     = (aw_addr_ff[1:0] == 2'h0) & (aw_addr_ff <= ADDR_EXT_PRIO);
  wire ctrl_wr    = wr_en & sel_ctrl;
  wire [3:0] an_wbits = {wdata_ff[BIT_VDET], wdata_ff[BIT_ZCD],
                         wdata_ff[BIT_CMPB], wdata_ff[BIT_CMPA]};
  wire [2:0] gflag_clr = (wr_en & sel_gflag) ? wdata_ff[2:0] : 3'h0;
  wire [2:0] eflag_clr = (wr_en & sel_eflag) ? wdata_ff[2:0] : 3'h0;
  wire [3:0] aflag_clr = (wr_en & sel_aflag) ? an_wbits : 4'h0;
  // ==========================================================
  // Read decode, unimplemented bits forced to zero
  wire [7:0] an_rd_flag = {an_flag_w[3:2], 4'h0, an_flag_w[1:0]};
  wire [7:0] an_rd_en   = {an_en_ff[3:2], 4'h0, an_en_ff[1:0]};
  wire [7:0] an_rd_prio = {an_prio_ff[3:2], 4'h0, an_prio_ff[1:0]};
  wire [7:0] ctrl_rd    = {ghe_ff, ple_ff, pri_ff, 2'h0, edge_ff};
  wire [7:0] rd_raw =
    (s_axi_araddr == ADDR_GLOBAL_CTRL) ? (ctrl_rd & MASK_CTRL) :
    (s_axi_araddr == ADDR_GATE_FLAG)   ? {5'h0, gate_flag_w} :
    (s_axi_araddr == ADDR_ANALOG_EN)   ? (an_rd_en & MASK_ANALOG) :
    (s_axi_araddr == ADDR_EXT_FLAG)    ? {5'h0, ext_flag_w} :
    (s_axi_araddr == ADDR_ANALOG_FLAG) ? (an_rd_flag & MASK_ANALOG) :
    (s_axi_araddr == ADDR_GATE_EN)     ? {5'h0, gate_en_ff} :
    (s_axi_araddr == ADDR_EXT_EN)      ? {5'h0, ext_en_ff} :
    (s_axi_araddr == ADDR_GATE_PRIO)   ? {5'h0, gate_prio_ff} :
    (s_axi_araddr == ADDR_ANALOG_PRIO) ? (an_rd_prio & MASK_ANALOG) :
    (s_axi_araddr == ADDR_EXT_PRIO)    ? {5'h0, ext_prio_ff, 1'b0} :
                                         8'h00;
  wire rd_hit = (s_axi_araddr[1:0] == 2'h0) & (s_axi_araddr <= ADDR_EXT_PRIO);

  // ==========================================================
  // Bus handshake
  always_comb begin
    nxt_wr_st = wr_st_ff;
    case (wr_st_ff)
      WR_COLLECT: if (wr_fire) nxt_wr_st = WR_RESP;
      WR_RESP:    if (b_hs) nxt_wr_st = WR_COLLECT;
      default:    nxt_wr_st = WR_COLLECT;
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_st_ff   <= WR_COLLECT;
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      aw_addr_ff <= 8'h00;
      wdata_ff   <= 8'h00;
      wstrb0_ff  <= 1'b0;
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
    end else begin
      wr_st_ff <= nxt_wr_st;
      if (aw_hs) begin
        aw_got_ff  <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
        awready_ff <= 1'b0;
      end else if (wr_fire) begin
        aw_got_ff <= 1'b0;
      end else if (b_hs) begin
        awready_ff <= 1'b1;
      end
      if (w_hs) begin
        w_got_ff  <= 1'b1;
        wdata_ff  <= s_axi_wdata[7:0];
        wstrb0_ff <= s_axi_wstrb[0];
        wready_ff <= 1'b0;
      end else if (wr_fire) begin
        w_got_ff <= 1'b0;
      end else if (b_hs) begin
        wready_ff <= 1'b1;
      end
      bvalid_ff <= (nxt_wr_st == WR_RESP);
      if (wr_fire) bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 8'h00;
      rresp_ff   <= RESP_OKAY;
    end else if (ar_hs) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rdata_ff   <= rd_raw;   // see RULE9
      rresp_ff   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (r_hs) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = {24'h0, rdata_ff};

  // ==========================================================
  // Global control; a bus write wins over a hardware clear
  wire ghe_clr = pri_ff ? ack_high : (ack_high | ack_low); // see RULE1
  wire ple_clr = pri_ff & ack_low;                          // see RULE3
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ghe_ff  <= RST_CTRL[BIT_GLOBAL_HIGH];
      ple_ff  <= RST_CTRL[BIT_PERIPH_LOW];
      pri_ff  <= RST_CTRL[BIT_PRIO_ON];
      edge_ff <= RST_CTRL[2:0];
    end else if (ctrl_wr) begin
      ghe_ff  <= wdata_ff[BIT_GLOBAL_HIGH];
      ple_ff  <= wdata_ff[BIT_PERIPH_LOW];
      pri_ff  <= wdata_ff[BIT_PRIO_ON];      // see RULE5
      edge_ff <= wdata_ff[2:0];              // see RULE6
    end else begin
      if (ghe_clr) ghe_ff <= 1'b0;           // see RULE2
      if (ple_clr) ple_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Enable and priority registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gate_en_ff   <= RST_ZERO3;
      ext_en_ff    <= RST_ZERO3;
      an_en_ff     <= RST_ZERO4;
      gate_prio_ff <= RST_ZERO3;
      an_prio_ff   <= RST_ZERO4;
      ext_prio_ff  <= RST_ZERO3[1:0];
    end else begin
      if (wr_en & sel_an_en) an_en_ff <= an_wbits; // see RULE11, RULE12
      if (wr_en & sel_g_en)  gate_en_ff <= wdata_ff[2:0];
      if (wr_en & sel_e_en)  ext_en_ff <= wdata_ff[2:0];
      if (wr_en & sel_gprio) gate_prio_ff <= wdata_ff[2:0];
      if (wr_en & sel_aprio) an_prio_ff <= an_wbits;
      if (wr_en & sel_eprio) ext_prio_ff <= wdata_ff[2:1];
    end
  end

  // ==========================================================
  // Event capture
  assign ext_pin_vec = {ext_pins.ext_irq_pin_c, ext_pins.ext_irq_pin_b,
                        ext_pins.ext_irq_pin_a};

  for (genvar i = 0; i < 3; i++) begin : g_edge
    icl_edge_det u_edge (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .pin      (ext_pin_vec[i]),
      .rise_sel (edge_ff[i]),     // see RULE6
      .evt      (ext_evt[i])
    );
  end
  // Flags set independent of all enables
  icl_flag_cell #(.W(3)) u_ext_flag (
    .sys_clk (sys_clk),
    .rst     (rst),
    .set     (ext_evt),           // see RULE7
    .clr     (eflag_clr),
    .q_ff    (ext_flag_w)
  );

  icl_flag_cell #(.W(3)) u_gate_flag (
    .sys_clk (sys_clk),
    .rst     (rst),
    .set     (src_in.gate_evt),   // see RULE10
    .clr     (gflag_clr),
    .q_ff    (gate_flag_w)
  );

  icl_flag_cell #(.W(4)) u_an_flag (
    .sys_clk (sys_clk),
    .rst     (rst),
    .set     (src_in.analog_evt),
    .clr     (aflag_clr),
    .q_ff    (an_flag_w)
  );

  // ==========================================================
  // Request generation
  wire [2:0] pend_core   = ext_flag_w & ext_en_ff;
  wire [6:0] pend_periph = {gate_flag_w & gate_en_ff, an_flag_w & an_en_ff};
  wire [9:0] pend_all    = {pend_core, pend_periph};
  wire [9:0] prio_all    = {ext_prio_ff, 1'b1, gate_prio_ff, an_prio_ff};
  wire hi_any  = |(pend_all & prio_all);
  wire lo_any  = |(pend_all & ~prio_all);
  wire single  = ghe_ff & ((|pend_core) | (ple_ff & (|pend_periph)));
  wire req_hi  = pri_ff ? (ghe_ff & hi_any) : single;   // see RULE13
  wire req_lo  = pri_ff & ghe_ff & ple_ff & lo_any & ~req_hi;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      core_req_ff <= '0;
      irq_ff      <= 1'b0;
    end else begin
      core_req_ff.req_high <= req_hi;                   // see RULE4
      core_req_ff.req_low  <= req_lo;                   // see RULE5
      irq_ff               <= |pend_all;
    end
  end

  // ==========================================================
  // Checks
  AST_GHE_HI_CLR: assert property (@(posedge sys_clk) disable iff (rst) // see RULE1
    pri_ff && ack_high && !ctrl_wr |=> !ghe_ff && !core_req_ff.req_low)
    else $error("global high enable not cleared on high take");
  AST_GHE_ANY_CLR: assert property (@(posedge sys_clk) disable iff (rst) // see RULE2
    !pri_ff && (ack_high || ack_low) && !ctrl_wr |=>
      !ghe_ff ##1 !core_req_ff.req_high)
    else $error("global enable not cleared on take");
  AST_PLE_CLR: assert property (@(posedge sys_clk) disable iff (rst) // see RULE3
    pri_ff && ack_low && !ack_high && !ctrl_wr |=> !ple_ff && ghe_ff == $past(ghe_ff))
    else $error("low enable clear wrong");
  AST_PERIPH_GATE: assert property (@(posedge sys_clk) disable iff (rst) // see RULE4
    !pri_ff && !ple_ff && pend_core == 3'h0 |=> !core_req_ff.req_high)
    else $error("peripheral request passed a closed gate");
  AST_SINGLE_NO_LOW: assert property (@(posedge sys_clk) disable iff (rst) // see RULE5
    !pri_ff |=> !core_req_ff.req_low)
    else $error("low request in single-level mode");
  AST_RSVD_ZERO: assert property (@(posedge sys_clk) disable iff (rst) // see RULE9
    ar_hs && s_axi_araddr == ADDR_GLOBAL_CTRL |=> s_axi_rdata[4:3] == 2'h0
      && s_axi_rdata[31:8] == 24'h0)
    else $error("unimplemented bits not zero");
  AST_AN_EN_HI: assert property (@(posedge sys_clk) disable iff (rst) // see RULE11
    wr_en && sel_an_en |=> an_en_ff[3:2] == $past(wdata_ff[7:6]))
    else $error("analog enable upper bits wrong");
  AST_AN_EN_LO: assert property (@(posedge sys_clk) disable iff (rst) // see RULE12
    wr_en && sel_an_en |=> an_en_ff[1:0] == $past(wdata_ff[1:0]))
    else $error("comparator enable bits wrong");
  AST_PREEMPT: assert property (@(posedge sys_clk) disable iff (rst) // see RULE13
    pri_ff && ghe_ff && hi_any |=> core_req_ff.req_high && !core_req_ff.req_low)
    else $error("high request did not preempt low");
endmodule : icl_top

// ==== interrupt_control_logic_tb.sv ====
// Purpose: Self-checking bench of the interrupt control logic
// Assumes: Core model acknowledges every request it sees
// Notes:   Register access only through AXI4-Lite tasks
`timescale 1ns/1ps
module interrupt_control_logic_tb;
  import icl_pkg::*;
  // ==========================================================
  // Signals
  logic          sys_clk = 1'b0;
  logic          rst = 1'b1;
  logic [7:0]    awaddr = '0, araddr = '0;
  logic          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic          arvalid = 1'b0, rready = 1'b0;
  logic [31:0]   wdata = '0, rdata;
  logic          awready, wready, bvalid, arready, rvalid;
  logic [1:0]    bresp, rresp;
  icl_src_t      src = '0;
  icl_ext_t      pins = '0;
  logic          ack_high, ack_low, irq;
  icl_core_req_t req;
  logic [31:0]   rd;
  logic [1:0]    rsp;
  int            num_errors = 0;
  int            checks = 0;
  logic [7:0]    amap [4] = '{8'h01, 8'h02, 8'h40, 8'h80};

  always #2.5 sys_clk = ~sys_clk;

  icl_top icl_top_i (
    .sys_clk(sys_clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .src_in(src), .ext_pins(pins), .ack_high(ack_high),
    .ack_low(ack_low), .core_req_ff(req), .irq_ff(irq)
  );

  icl_core_model icl_core_model_i (
    .sys_clk(sys_clk), .rst(rst), .req(req),
    .ack_high(ack_high), .ack_low(ack_low)
  );

  // ==========================================================
  // Tasks
  task automatic chk(input string name, input logic [31:0] got,
                     input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s exp %h got %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    @(posedge sys_clk);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (!aw_done && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    logic ar_done;
    ar_done = 1'b0;
    @(posedge sys_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (!ar_done && arready) begin
        ar_done = 1'b1;
        arvalid <= 1'b0;
      end
    end while (rvalid !== 1'b1);
    rd  = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask : rdr

  // One-cycle event pulse, then time for flag and outputs to settle
  task automatic ev(input logic [6:0] v, input int wait_n);
    @(posedge sys_clk);
    src <= icl_src_t'(v);
    @(posedge sys_clk);
    src <= '0;
    repeat (wait_n) @(posedge sys_clk);
    #1;
  endtask : ev

  task automatic final_report;
    if (num_errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  // ==========================================================
  // Watchdog
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    final_report();
  end

  // ==========================================================
  // Tests
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    rdr(ADDR_GLOBAL_CTRL); chk("ctrl reset", rd, 32'h07);
    rdr(ADDR_ANALOG_EN); chk("analog en reset", rd, 32'h0);
    rdr(8'h28); chk("unmapped rresp", {30'h0, rsp}, 32'h2);
    wr(8'h28, 8'hff); chk("unmapped bresp", {30'h0, rsp}, 32'h2);
    wr(ADDR_GLOBAL_CTRL, 8'h1f);
    rdr(ADDR_GLOBAL_CTRL); chk("ctrl mask", rd, 32'h07);
    wr(ADDR_ANALOG_EN, 8'hff);
    rdr(ADDR_ANALOG_EN); chk("analog en mask", rd, 32'hc3);
    // Gate flags set with gate and global enables off, cleared only by a write
    for (int i = 0; i < 3; i++) begin
      ev(7'h10 << i, 4);
      chk("gate irq off", {31'h0, irq}, 32'h0);
      rdr(ADDR_GATE_FLAG); chk("gate flag", rd, 32'h1 << i);
      wr(ADDR_GATE_FLAG, 8'hff);
      rdr(ADDR_GATE_FLAG); chk("gate clear", rd, 32'h0);
    end
    // Each analog enable bit gates only its own source
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_ANALOG_FLAG, 8'hc3);
      wr(ADDR_ANALOG_EN, amap[i]);
      ev(7'h0f & ~(7'h1 << i), 4);
      chk("analog other", {31'h0, irq}, 32'h0);
      ev(7'h1 << i, 4);
      chk("analog own", {31'h0, irq}, 32'h1);
    end
    rdr(ADDR_ANALOG_FLAG); chk("analog flags", rd, 32'hc3);
    wr(ADDR_ANALOG_EN, 8'h00);
    // Edge select: rising on c and a, falling on b
    wr(ADDR_GLOBAL_CTRL, 8'h05);
    @(posedge sys_clk) pins <= 3'b111;
    rdr(ADDR_EXT_FLAG); chk("ext rise", rd, 32'h5);
    wr(ADDR_EXT_FLAG, 8'h07);
    @(posedge sys_clk) pins <= 3'b000;
    rdr(ADDR_EXT_FLAG); chk("ext fall", rd, 32'h2);
    wr(ADDR_EXT_FLAG, 8'h07);
    // Two-level: a low take clears only the low enable
    wr(ADDR_GATE_EN, 8'h01);
    wr(ADDR_GLOBAL_CTRL, 8'he7);
    ev(7'h10, 12);
    rdr(ADDR_GLOBAL_CTRL); chk("low take", rd, 32'ha7);
    wr(ADDR_GATE_FLAG, 8'h01);
    // Two-level: a high take clears only the high enable
    wr(ADDR_GATE_PRIO, 8'h01);
    wr(ADDR_GLOBAL_CTRL, 8'he7);
    ev(7'h10, 12);
    rdr(ADDR_GLOBAL_CTRL); chk("high take", rd, 32'h67);
    wr(ADDR_GATE_FLAG, 8'h01);
    // Single level: any take clears the global enable
    wr(ADDR_GLOBAL_CTRL, 8'hc7);
    ev(7'h10, 12);
    rdr(ADDR_GLOBAL_CTRL); chk("single take", rd, 32'h47);
    wr(ADDR_GATE_FLAG, 8'h01);
    // Single level with peripheral enable off blocks the request
    wr(ADDR_GLOBAL_CTRL, 8'h87);
    ev(7'h10, 6);
    chk("periph block", {30'h0, req}, 32'h0);
    chk("periph irq", {31'h0, irq}, 32'h1);
    rdr(ADDR_GLOBAL_CTRL); chk("no take", rd, 32'h87);
    // External pins are core sources and pass the closed peripheral gate
    wr(ADDR_EXT_EN, 8'h01);
    @(posedge sys_clk) pins <= 3'b001;
    repeat (12) @(posedge sys_clk);
    rdr(ADDR_GLOBAL_CTRL); chk("core take", rd, 32'h07);
    final_report();
  end
endmodule : interrupt_control_logic_tb
